/* File: psl_link.sv */
// Eight-channel pseudo-SONET link: framing, scrambling, alignment, bypass
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
// Behaviour
// - Two groups of four, format per group
// - Receive bytes keep transmitted order
// - Receiver hunts A1/A2 for frame boundary
// - Scramble transmit, descramble receive
// - Elastic FIFOs align channels to local frame
// - Realign frames on local frame pulse
// - One reference clock, forwarded to fabric
// - Line rate eight, four or two times clock
// - FIFO written recovered side, read local
// - Unaligned receive timed by recovered clock
// - Bypass skips framing and scrambling
// - Half rate uses bits 7:4
// - Quarter rate uses bits 7:6
// - Rate chosen per channel, mixed freely
// - Scrambler 1+x6+x7, seeded, skips framing bytes
// - Alarm beyond 18 clocks misalignment
module psl_link (
	input wire logic pclk, // Reference clock, 63 to 106.25 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic [psl_pkg::ADDR_W-1:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic core_clk_to_fabric, // Reference clock to fabric
	input wire logic system_frame_pulse, // Local frame pulse from fabric
	input wire logic [63:0] tx_byte_in, // Transmit bytes, channel i at [8i+:8]
	output logic [63:0] tx_line_byte, // Bytes to serializer
	output logic [15:0] line_rate_sel, // Serializer rate per channel
	input wire logic [63:0] rx_line_byte, // Bytes from deserializer
	input wire logic [7:0] rx_recovered_clk, // Recovered clocks
	output logic [7:0] rx_clk_to_fabric, // Recovered clocks to fabric
	output logic [63:0] rx_byte_out, // Received bytes
	output logic [7:0] rx_byte_valid, // Byte strobe per channel
	output logic [7:0] rx_payload_flag, // Byte lies in payload
	output logic [7:0] rx_frame_pulse // First byte of a frame
);
	import psl_pkg::*;

	typedef struct packed {
		logic scr_en;
		logic align_en;
		psl_fmt_type [NUM_GRP-1:0] fmt;
		logic [7:0] bypass;
		logic [15:0] rate;
		logic [NUM_GRP-1:0] alarm;
		logic [31:0] prdata;
		logic [63:0] tx;
		logic [NUM_GRP-1:0][10:0] tcol;
		logic [NUM_GRP-1:0][3:0] trow;
		logic [NUM_GRP-1:0][6:0] tscr;
		logic [NUM_GRP-1:0][4:0] acnt;
		logic [NUM_GRP-1:0] go;
		psl_rxch_type [NUM_CH-1:0] ch;
	} psl_core_type;

	psl_core_type s_r;
	psl_core_type s_nxt;
	logic [NUM_CH-1:0][FIFO_W-1:0] rdata;

	// ------------------------------------------------------------
	// Alignment FIFOs
	// ------------------------------------------------------------
	// Written on recovered-clock ticks, read against local timing
	for (genvar i = 0; i < NUM_CH; i++) begin : g_mem
		psl_align_mem u_mem (
			.pclk(pclk),
			.we(s_r.ch[i].we),
			.waddr(s_r.ch[i].waddr),
			.wdata(s_r.ch[i].wdata),
			.raddr(s_r.ch[i].rptr),
			.rdata(rdata[i])
		);
		assign rx_byte_out[i*8 +: 8] = s_r.ch[i].out;
		assign rx_byte_valid[i] = s_r.ch[i].val;
		assign rx_payload_flag[i] = s_r.ch[i].pay;
		assign rx_frame_pulse[i] = s_r.ch[i].fp;
	end

	// Clocks forwarded straight through; the recovered clocks are also sampled by the receive logic
	assign core_clk_to_fabric = pclk;
	assign rx_clk_to_fabric = rx_recovered_clk;
	assign tx_line_byte = s_r.tx;
	assign line_rate_sel = s_r.rate;
	assign prdata = s_r.prdata;
	assign pready = 1'b1;

	// Unmapped decode for the error answer; read capture uses its own case default
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == REG_CTRL) || (a == REG_BYPASS) || (a == REG_RATE) || (a == REG_STATUS);
	endfunction

	assign pslverr = psel && penable && !mapped(paddr);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic wr;
		logic [10:0] n;
		logic [10:0] col;
		logic [3:0] row;
		logic [6:0] st;
		logic [14:0] ks;
		logic [7:0] b;
		logic [7:0] key;
		logic hit;
		logic [NUM_GRP-1:0][3:0] seen;
		logic [NUM_GRP-1:0] realign;
		logic [NUM_GRP-1:0] alarm_set;
		int g;
		wr = 1'b0;
		n = '0;
		col = '0;
		row = '0;
		st = '0;
		ks = '0;
		b = '0;
		key = '0;
		hit = 1'b0;
		seen = '0;
		realign = '0;
		alarm_set = '0;
		g = 0;
		s_nxt = s_r;

		// Register writes; read data captured in the setup phase
		wr = psel && penable && pwrite;
		if (psel && !penable) begin
			case (paddr)
				REG_CTRL: s_nxt.prdata = {26'h0, 2'(s_r.fmt[1]), 2'(s_r.fmt[0]), s_r.align_en, s_r.scr_en};
				REG_BYPASS: s_nxt.prdata = {24'h0, s_r.bypass};
				REG_RATE: s_nxt.prdata = {16'h0, s_r.rate};
				REG_STATUS: begin
					s_nxt.prdata = '0;
					for (int i = 0; i < NUM_CH; i++) begin
						s_nxt.prdata[STAT_LOCK_LSB + i] = (s_r.ch[i].st == RX_SYNC);
					end
					s_nxt.prdata[STAT_ALARM_LSB +: NUM_GRP] = s_r.alarm;
				end
				default: s_nxt.prdata = '0;
			endcase
		end
		if (wr) begin
			case (paddr)
				REG_CTRL: begin
					s_nxt.scr_en = pwdata[CTRL_SCR_BIT];
					s_nxt.align_en = pwdata[CTRL_ALIGN_BIT];
					s_nxt.fmt[0] = psl_fmt_type'(pwdata[CTRL_FMTA_LSB +: 2]);
					s_nxt.fmt[1] = psl_fmt_type'(pwdata[CTRL_FMTB_LSB +: 2]);
				end
				REG_BYPASS: s_nxt.bypass = pwdata[7:0];
				REG_RATE: s_nxt.rate = pwdata[15:0];
				REG_STATUS: s_nxt.alarm = s_r.alarm & ~pwdata[STAT_ALARM_LSB +: NUM_GRP];
				default: ;
			endcase
		end

		// Transmit framer per group, restarted by the local frame pulse
		for (int gi = 0; gi < NUM_GRP; gi++) begin
			n = n_of(s_r.fmt[gi]);
			col = system_frame_pulse ? 11'h000 : s_r.tcol[gi];
			row = system_frame_pulse ? 4'h0 : s_r.trow[gi];
			st = (row == 4'h0 && col == 11'(3 * n)) ? SCR_SEED : s_r.tscr[gi];
			ks = scr_step(st);
			key = (row == 4'h0 && col < 11'(3 * n)) || !s_r.scr_en ? 8'h00 : ks[14:7];
			s_nxt.tscr[gi] = ks[6:0];
			for (int k = 0; k < CH_PER_GRP; k++) begin
				g = gi * CH_PER_GRP + k;
				b = tx_byte_in[g*8 +: 8];
				if (s_r.bypass[g]) begin
					// Raw bytes straight to the serializer, idle lanes zeroed
					s_nxt.tx[g*8 +: 8] = b & rate_mask(s_r.rate[g*2 +: 2]);
				end else if (row == 4'h0 && col < n) begin
					s_nxt.tx[g*8 +: 8] = A1_BYTE;
				end else if (row == 4'h0 && col < 11'(2 * n)) begin
					s_nxt.tx[g*8 +: 8] = A2_BYTE;
				end else begin
					s_nxt.tx[g*8 +: 8] = b ^ key;
				end
			end
			if (col == cols_of(s_r.fmt[gi]) - 11'h001) begin
				s_nxt.tcol[gi] = 11'h000;
				s_nxt.trow[gi] = (row == ROWS_PER_FRAME - 4'h1) ? 4'h0 : row + 4'h1;
			end else begin
				s_nxt.tcol[gi] = col + 11'h001;
				s_nxt.trow[gi] = row;
			end
		end

		// Receive channels
		for (int i = 0; i < NUM_CH; i++) begin
			g = i / CH_PER_GRP;
			n = n_of(s_r.fmt[g]);
			// Two-stage capture of pin-side data and recovered clock
			s_nxt.ch[i].d1 = rx_line_byte[i*8 +: 8];
			s_nxt.ch[i].d2 = s_r.ch[i].d1;
			s_nxt.ch[i].c1 = rx_recovered_clk[i];
			s_nxt.ch[i].c2 = s_r.ch[i].c1;
			s_nxt.ch[i].c3 = s_r.ch[i].c2;
			s_nxt.ch[i].we = 1'b0;
			s_nxt.ch[i].val = 1'b0;
			s_nxt.ch[i].fp = 1'b0;
			s_nxt.ch[i].rd_pend = 1'b0;
			if (s_r.ch[i].c2 && !s_r.ch[i].c3) begin
				// One byte per recovered clock edge, in arrival order
				b = s_r.ch[i].d2;
				s_nxt.ch[i].prev = b;
				hit = (s_r.ch[i].prev == A1_BYTE) && (b == A2_BYTE);
				col = s_r.ch[i].col;
				row = s_r.ch[i].row;
				if (s_r.bypass[i]) begin
					s_nxt.ch[i].out = b & rate_mask(s_r.rate[i*2 +: 2]);
					s_nxt.ch[i].val = 1'b1;
					s_nxt.ch[i].pay = 1'b0;
					s_nxt.ch[i].st = RX_HUNT;
				end else begin
					case (s_r.ch[i].st)
						RX_HUNT: begin
							// First A1 to A2 boundary fixes the byte position
							if (hit) begin
								s_nxt.ch[i].st = RX_SYNC;
								s_nxt.ch[i].col = n + 11'h001;
								s_nxt.ch[i].row = 4'h0;
							end
						end
						RX_SYNC: begin
							// A missed boundary drops lock and restarts the hunt
							if (row == 4'h0 && col == n && !hit) begin
								s_nxt.ch[i].st = RX_HUNT;
							end
							st = (row == 4'h0 && col == 11'(3 * n)) ? SCR_SEED : s_r.ch[i].scr;
							ks = scr_step(st);
							s_nxt.ch[i].scr = ks[6:0];
							key = (row == 4'h0 && col < 11'(3 * n)) || !s_r.scr_en ? 8'h00 : ks[14:7];
							b = b ^ key;
							s_nxt.ch[i].out = b;
							s_nxt.ch[i].pay = (col >= 11'(3 * n));
							s_nxt.ch[i].fp = (row == 4'h0 && col == 11'h000) && !s_r.align_en;
							s_nxt.ch[i].val = !s_r.align_en;
							s_nxt.ch[i].we = s_r.align_en;
							s_nxt.ch[i].waddr = s_r.ch[i].wptr;
							s_nxt.ch[i].wdata = {row == 4'h0 && col == 11'h000, col >= 11'(3 * n), b};
							s_nxt.ch[i].wptr = s_r.ch[i].wptr + 5'h01;
							if (s_r.align_en && row == 4'h0 && col == 11'h000) begin
								s_nxt.ch[i].mark = s_r.ch[i].wptr;
								s_nxt.ch[i].seen = 1'b1;
							end
							if (col == cols_of(s_r.fmt[g]) - 11'h001) begin
								s_nxt.ch[i].col = 11'h000;
								s_nxt.ch[i].row = (row == ROWS_PER_FRAME - 4'h1) ? 4'h0 : row + 4'h1;
							end else begin
								s_nxt.ch[i].col = col + 11'h001;
							end
						end
						default: s_nxt.ch[i].st = RX_HUNT;
					endcase
				end
			end
			seen[g][i % CH_PER_GRP] = s_r.ch[i].seen;
		end

		// Group alignment: spread of frame marks, then realign on local pulse
		for (int gi = 0; gi < NUM_GRP; gi++) begin
			if (!s_r.align_en || &seen[gi] || ~|seen[gi]) begin
				s_nxt.acnt[gi] = 5'h00;
			end else begin
				s_nxt.acnt[gi] = s_r.acnt[gi] + 5'h01;
			end
			alarm_set[gi] = s_r.acnt[gi] >= ALIGN_TOL;
			realign[gi] = s_r.align_en && system_frame_pulse && &seen[gi];
			if (!s_r.align_en) begin
				s_nxt.go[gi] = 1'b0;
			end else if (realign[gi]) begin
				s_nxt.go[gi] = 1'b1;
			end
		end
		// Set wins over a software clear in the same cycle
		s_nxt.alarm = s_nxt.alarm | alarm_set;

		// FIFO read side, local timing
		for (int i = 0; i < NUM_CH; i++) begin
			g = i / CH_PER_GRP;
			if (alarm_set[g] || realign[g]) begin
				s_nxt.ch[i].seen = 1'b0;
			end
			if (realign[g]) begin
				s_nxt.ch[i].rptr = s_r.ch[i].mark;
			end else if (s_r.go[g] && s_r.ch[i].rptr != s_r.ch[i].wptr
				&& !(s_r.ch[i].we && s_r.ch[i].rptr == s_r.ch[i].waddr)) begin
				s_nxt.ch[i].rptr = s_r.ch[i].rptr + 5'h01;
				s_nxt.ch[i].rd_pend = 1'b1;
			end
			if (s_r.ch[i].rd_pend && !s_r.bypass[i]) begin
				s_nxt.ch[i].out = rdata[i][7:0];
				s_nxt.ch[i].pay = rdata[i][8];
				s_nxt.ch[i].fp = rdata[i][9];
				s_nxt.ch[i].val = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.scr_en <= RST_SCR_EN;
			s_r.align_en <= RST_ALIGN_EN;
			s_r.fmt[0] <= FMT_STS12;
			s_r.fmt[1] <= FMT_STS12;
			s_r.bypass <= RST_BYPASS;
			s_r.rate <= RST_RATE;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

/* File: psl_pkg.sv */
// Shared constants, types and helpers for the pseudo-SONET link logic
package psl_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on APB)
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BYPASS = 8'h04;
	localparam logic [7:0] REG_RATE = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam int ADDR_W = 8;

	// CTRL fields
	localparam int CTRL_SCR_BIT = 0;
	localparam int CTRL_ALIGN_BIT = 1;
	localparam int CTRL_FMTA_LSB = 2;
	localparam int CTRL_FMTB_LSB = 4;
	// STATUS fields
	localparam int STAT_LOCK_LSB = 0;
	localparam int STAT_ALARM_LSB = 8;

	// Reset values
	localparam logic RST_SCR_EN = 1'b1;
	localparam logic RST_ALIGN_EN = 1'b0;
	localparam logic [7:0] RST_BYPASS = 8'h00;
	localparam logic [15:0] RST_RATE = 16'h0000;

	// ------------------------------------------------------------
	// Channels and framing
	// ------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int NUM_GRP = 2;
	localparam int CH_PER_GRP = 4;
	localparam logic [7:0] A1_BYTE = 8'hF6;
	localparam logic [7:0] A2_BYTE = 8'h28;
	localparam logic [10:0] N_STS3 = 11'h003;
	localparam logic [10:0] N_STS12 = 11'h00C;
	localparam int COLS_PER_STS1 = 90;
	localparam logic [3:0] ROWS_PER_FRAME = 4'h9;
	localparam int FRAME_CLKS = 9720;
	localparam logic [6:0] SCR_SEED = 7'h7F;

	// Rate codes and parallel bus lane masks
	localparam logic [1:0] RATE_FULL = 2'h0;
	localparam logic [1:0] RATE_HALF = 2'h1;
	localparam logic [1:0] RATE_QUARTER = 2'h2;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_HALF = 8'hF0;
	localparam logic [7:0] MASK_QUARTER = 8'hC0;

	// Alignment FIFO
	localparam int FIFO_AW = 5;
	localparam int FIFO_W = 10;
	localparam logic [4:0] ALIGN_TOL = 5'h12;

	typedef enum logic [1:0] {FMT_STS3, FMT_STS12, FMT_STS48} psl_fmt_type;
	typedef enum logic {RX_HUNT, RX_SYNC} psl_rxst_type;

	// Per-channel receive state
	typedef struct packed {
		logic [7:0] d1;
		logic [7:0] d2;
		logic c1;
		logic c2;
		logic c3;
		logic [7:0] prev;
		psl_rxst_type st;
		logic [10:0] col;
		logic [3:0] row;
		logic [6:0] scr;
		logic [4:0] wptr;
		logic [4:0] waddr;
		logic [4:0] rptr;
		logic [4:0] mark;
		logic seen;
		logic we;
		logic [9:0] wdata;
		logic rd_pend;
		logic [7:0] out;
		logic val;
		logic pay;
		logic fp;
	} psl_rxch_type;

	// STS-1 count carried per channel for a group format
	function automatic logic [10:0] n_of(input psl_fmt_type f);
		n_of = (f == FMT_STS3) ? N_STS3 : N_STS12;
	endfunction

	// Row length in bytes for a group format
	function automatic logic [10:0] cols_of(input psl_fmt_type f);
		cols_of = 11'(n_of(f) * COLS_PER_STS1);
	endfunction

	// Parallel lanes carrying data at a bypass rate
	function automatic logic [7:0] rate_mask(input logic [1:0] r);
		case (r)
			RATE_HALF: rate_mask = MASK_HALF;
			RATE_QUARTER: rate_mask = MASK_QUARTER;
			default: rate_mask = MASK_FULL;
		endcase
	endfunction

	// One byte of the 1+x^6+x^7 sequence: {key, next state}, MSB first
	function automatic logic [14:0] scr_step(input logic [6:0] s);
		logic [6:0] t;
		logic [7:0] k;
		t = s;
		k = 8'h00;
		for (int b = 7; b >= 0; b--) begin
			k[b] = t[6];
			t = {t[5:0], t[6] ^ t[5]};
		end
		scr_step = {k, t};
	endfunction

endpackage

/* File: psl_align_mem.sv */
// Alignment FIFO storage, one channel, registered read data
`timescale 1ns/1ps
module psl_align_mem (
	input wire logic pclk, // Reference clock
	input wire logic we, // Write strobe
	input wire logic [psl_pkg::FIFO_AW-1:0] waddr, // Write address
	input wire logic [psl_pkg::FIFO_W-1:0] wdata, // Write word
	input wire logic [psl_pkg::FIFO_AW-1:0] raddr, // Read address
	output logic [psl_pkg::FIFO_W-1:0] rdata // Registered read word
);
	import psl_pkg::*;

	logic [FIFO_W-1:0] mem [0:(1 << FIFO_AW)-1];

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// No reset on the array; contents are only read after a frame mark
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule

/* File: psl_link_assertions.sv */
// Checker of the link block's port behaviour
`timescale 1ns/1ps
module psl_link_chk (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic [7:0] paddr, // Bus address
	input wire logic psel, // Bus select
	input wire logic penable, // Bus enable
	input wire logic pwrite, // Bus direction
	input wire logic [31:0] pwdata, // Bus write data
	input wire logic core_clk_to_fabric, // Forwarded clock
	input wire logic system_frame_pulse, // Local frame pulse
	input wire logic [63:0] tx_byte_in, // Fabric bytes
	input wire logic [63:0] tx_line_byte, // Line bytes
	input wire logic [15:0] line_rate_sel, // Rate per channel
	input wire logic [7:0] rx_recovered_clk, // Recovered clocks
	input wire logic [7:0] rx_clk_to_fabric, // Forwarded recovered clocks
	input wire logic [7:0] rx_byte_valid, // Byte strobes
	input wire logic [7:0] rx_payload_flag, // Payload flags
	input wire logic [7:0] rx_frame_pulse // Frame starts
);
	logic [7:0] byp_r;
	logic aln_r;
	logic wr;
	assign wr = psel && penable && pwrite;
	// ------------------------------------------------------------
	// Shadow of the bypass register, since the ports do not show it
	// ------------------------------------------------------------
	// Alignment enable shadowed too: aligned reads may run back to back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byp_r <= 8'h00;
			aln_r <= 1'b0;
		end else if (wr) begin
			if (paddr == 8'h04) byp_r <= pwdata[7:0];
			if (paddr == 8'h00) aln_r <= pwdata[1];
		end
	end
	function automatic logic [7:0] lane(input logic [1:0] r);
		return (r == 2'h1) ? 8'hF0 : (r == 2'h2) ? 8'hC0 : 8'hFF;
	endfunction
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	fwd_clock_a: assert property (!core_clk_to_fabric)
		else $error("forwarded clock not a copy");
	fwd_high_a: assert property (@(negedge pclk) core_clk_to_fabric)
		else $error("forwarded clock not high");
	rec_clock_a: assert property (rx_clk_to_fabric == rx_recovered_clk)
		else $error("recovered clock not forwarded");
	rate_copy_a: assert property (wr && paddr == 8'h08 |-> ##2 line_rate_sel == $past(pwdata[15:0], 2))
		else $error("rate select not updated");
	frame_start_a: assert property (!byp_r[0] && system_frame_pulse |=> tx_line_byte[7:0] == 8'hF6)
		else $error("no first framing byte");
	bypass_tx_a: assert property (byp_r[1] |=>
		tx_line_byte[15:8] == ($past(tx_byte_in[15:8]) & lane($past(line_rate_sel[3:2]))))
		else $error("bypass byte wrong");
	bypass_pay_a: assert property (byp_r[0] && rx_byte_valid[0] |-> !rx_payload_flag[0])
		else $error("payload flag in bypass");
	bypass_lat_a: assert property (byp_r[0] && $rose(rx_recovered_clk[0]) |-> ##[2:6] rx_byte_valid[0])
		else $error("bypass byte not delivered");
	valid_pulse_a: assert property (!aln_r && rx_byte_valid[0] |=> !rx_byte_valid[0])
		else $error("byte strobe too long");
	group_pulse_a: assert property (aln_r && rx_frame_pulse[0] |-> rx_frame_pulse[3:0] == 4'hF)
		else $error("group frame starts apart");
	pulse_byte_a: assert property (rx_frame_pulse[0] |-> rx_byte_valid[0] && !rx_payload_flag[0])
		else $error("frame pulse without byte");
endmodule
bind psl_link psl_link_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .core_clk_to_fabric,
	.system_frame_pulse, .tx_byte_in, .tx_line_byte, .line_rate_sel, .rx_recovered_clk, .rx_clk_to_fabric,
	.rx_byte_valid, .rx_payload_flag, .rx_frame_pulse);

/* File: psl_far_end.sv */
// Model of the remote transceiver feeding the receive links
`timescale 1ns/1ps
module psl_far_end (
	input wire logic clk, // Shared reference clock
	output logic [7:0] rclk = 8'h00, // Recovered clock per channel
	output logic [63:0] rdata = 64'h0 // Received byte per channel
);
	logic [7:0] q[$];
	logic [1:0] ph = 2'h0;
	logic busy = 1'b0;
	// One byte per four clocks from the same oscillator, so alignment stays legal
	// The clock stands still while idle and the line inverts the last byte every four clocks
	always @(posedge clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h0) begin
			rclk <= 8'h00;
			busy <= q.size() > 0;
			if (q.size() > 0) rdata <= {8{q.pop_front()}};
			else rdata <= ~rdata;
		end
		if (ph == 2'h2 && busy) rclk <= 8'hFF;
	end
endmodule

/* File: test_psl_link.sv */
// Self-checking bench of the link block
`timescale 1ns/1ps
`define CHK(nm, xp, gt) begin cmp_count++; if ((gt) !== (xp)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, xp, gt); end end
module test_psl_link;
	import psl_pkg::*;
	localparam logic [15:0] RT = 16'h24E4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, system_frame_pulse = 0, se, z;
	logic [7:0] paddr = 8'h00, d, dn, x, y;
	logic [31:0] pwdata = 32'h0, q, prdata;
	logic [63:0] tx_byte_in = 64'h0, w, tx_line_byte, rx_line_byte, rx_byte_out;
	logic [15:0] line_rate_sel;
	logic [7:0] rx_recovered_clk, rx_clk_to_fabric, rx_byte_valid, rx_payload_flag, rx_frame_pulse;
	logic pready, pslverr, core_clk_to_fabric;
	logic [6:0] sa, sb;
	logic [7:0] rq[$], bq[$];
	logic pq[$];
	integer seed = 32'hcf72;
	int err_total = 0, cmp_count = 0, mode = 0, go = 0, fs = 2430;
	psl_link dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.core_clk_to_fabric, .system_frame_pulse, .tx_byte_in, .tx_line_byte, .line_rate_sel, .rx_line_byte,
		.rx_recovered_clk, .rx_clk_to_fabric, .rx_byte_out, .rx_byte_valid, .rx_payload_flag, .rx_frame_pulse);
	psl_far_end far (.clk(pclk), .rclk(rx_recovered_clk), .rdata(rx_line_byte));
	always #5 pclk = ~pclk;
	// ------------------------------------------------------------
	// Reference model helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] key(inout logic [6:0] s);
		for (int b = 7; b >= 0; b--) begin
			key[b] = s[6];
			s = {s[5:0], s[6] ^ s[5]};
		end
	endfunction
	// Byte at frame position p for N interleaved columns
	function automatic logic [7:0] frm(int n, int p, logic [7:0] dv, inout logic [6:0] s);
		if (p == 3 * n) s = 7'h7F;
		if (p < n) return 8'hF6;
		if (p < 2 * n) return 8'h28;
		if (p < 3 * n) return dv;
		return dv ^ key(s);
	endfunction
	function automatic logic [7:0] lane(int i);
		return (RT[2*i+:2] == RATE_HALF) ? MASK_HALF : (RT[2*i+:2] == RATE_QUARTER) ? MASK_QUARTER : MASK_FULL;
	endfunction
	// ------------------------------------------------------------
	// Bus master and closing
	// ------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dv);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dv;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_far();
		int n;
		n = 0;
		while (far.q.size() > 0 && n < 30000) begin
			@(posedge pclk);
			n++;
		end
		repeat (20) @(posedge pclk);
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Receive monitor, sampled between edges
	always @(negedge pclk) begin
		if (mode >= 2 && rx_byte_valid[0] === 1'b1 && (go || rx_frame_pulse[0] === 1'b1) && rq.size() > 0) begin
			go = 1;
			`CHK("rx pulse", rq.size() == fs, rx_frame_pulse[0])
			y = rq.pop_front();
			z = pq.pop_front();
			`CHK("rx byte", y, rx_byte_out[7:0])
			`CHK("rx pay", z, rx_payload_flag[0])
			if (mode == 3) `CHK("rx group", 4'hF, rx_byte_valid[3:0])
		end
		if (mode == 1 && rx_byte_valid[0] === 1'b1) begin
			y = bq.pop_front();
			`CHK("rx strobes", 8'hFF, rx_byte_valid)
			for (int i = 0; i < 8; i++) `CHK("rx bypass", y & lane(i), rx_byte_out[8*i+:8])
		end
	end
	// Watchdog sized well above the longest test
	initial begin
		#600000;
		err_total++;
		stop_test();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0);
		`CHK("ctrl reset", 32'h15, q)
		apb(0, 8'h10, 0);
		`CHK("hole", 33'h100000000, {se, q})
		$display("test registers done");
		// Group A in STS-3, group B in STS-48 with bytes ordered by the fabric
		apb(1, 8'h00, 32'h21);
		sa = 7'h7F;
		sb = 7'h7F;
		d = 8'($random(seed));
		system_frame_pulse <= 1'b1;
		tx_byte_in <= {8{d}};
		for (int p = 0; p < 40; p++) begin
			@(posedge pclk);
			system_frame_pulse <= 1'b0;
			dn = 8'($random(seed));
			tx_byte_in <= {8{dn}};
			@(negedge pclk);
			x = frm(3, p, d, sa);
			`CHK("tx sts3", x, tx_line_byte[7:0])
			x = frm(12, p, d, sb);
			`CHK("tx sts48", x, tx_line_byte[39:32])
			d = dn;
		end
		@(posedge pclk);
		$display("test transmit framing done");
		// Two scrambled STS-3 frames; the second is checked byte for byte
		sa = 7'h7F;
		for (int k = 0; k < 4860; k++) begin
			d = 8'($random(seed));
			x = frm(3, k % 2430, d, sa);
			far.q.push_back(x);
			if (k >= 2430) rq.push_back((k % 2430 < 6) ? x : d);
			if (k >= 2430) pq.push_back(k % 270 >= 9);
		end
		mode = 2;
		wait_far();
		`CHK("rx left", 0, rq.size())
		apb(0, 8'h0C, 0);
		`CHK("lock", 1'b1, q[0])
		$display("test receive framing done");
		// Aligned receive: frame marks taken, bytes held until the local pulse
		apb(1, 8'h00, 32'h23);
		fs = 12;
		mode = 3;
		sa = 7'h7F;
		for (int k = 0; k < 12; k++) begin
			d = 8'($random(seed));
			x = frm(3, k, d, sa);
			far.q.push_back(x);
			rq.push_back((k < 6) ? x : d);
			pq.push_back(k >= 9);
		end
		wait_far();
		system_frame_pulse <= 1'b1;
		@(posedge pclk);
		system_frame_pulse <= 1'b0;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		`CHK("realign", 4'hF, rx_frame_pulse[3:0])
		repeat (20) @(posedge pclk);
		`CHK("aligned left", 0, rq.size())
		apb(0, 8'h0C, 0);
		`CHK("alarm", 2'h0, q[9:8])
		apb(1, 8'h00, 32'h21);
		$display("test alignment done");
		// Bypass with mixed rates and random data standing for the fabric's own coding
		apb(1, 8'h04, 32'hFF);
		apb(1, 8'h08, {16'h0, RT});
		`CHK("rate sel", RT, line_rate_sel)
		for (int c = 0; c < 8; c++) begin
			@(posedge pclk);
			w = {$random(seed), $random(seed)};
			tx_byte_in <= w;
			@(posedge pclk);
			@(negedge pclk);
			for (int i = 0; i < 8; i++) `CHK("tx bypass", w[8*i+:8] & lane(i), tx_line_byte[8*i+:8])
		end
		mode = 1;
		for (int c = 0; c < 8; c++) begin
			d = 8'($random(seed));
			bq.push_back(d);
			far.q.push_back(d);
		end
		wait_far();
		`CHK("bypass left", 0, bq.size())
		$display("test bypass done");
		stop_test();
	end
endmodule
